// ===== smbcc_consts.svh
// Offsets, reset values and timing counts of the clock config port.
// Functional notes
// - Device acknowledges the starting index byte.
// - Device acknowledges byte count before data.
// - Data stored ascending from index, each acknowledged.
// - Read begins with index write, repeated start.
// - Device acknowledges address with read direction.
// - Device sends count, then registers from index.
// - Slave address latched once from select pin.
// - Enable bits reset one; zero forces disable.
// - Spread pin level reads back in bits 7:6.
// - Software spread enable, reset zero, selects source.
// - Software spread field encoding, resets to zero.
// - Software amount ignored unless enable set.
// - Amplitude field, four levels, reset value two.
// - Per-output slew select, all reset fast.
// - Disabled pair state follows stop-state field.
// - Writable five-bit readback count, reset eight.
`ifndef SMBCC_CONSTS_SVH
`define SMBCC_CONSTS_SVH

`define SMBCC_IDX_OE        8'h00
`define SMBCC_IDX_SPREAD    8'h01
`define SMBCC_IDX_SLEW      8'h02
`define SMBCC_IDX_COUNT     8'h07
`define SMBCC_IDX_STOP      8'h0b

`define SMBCC_RST_OE        8'hff
`define SMBCC_RST_SW_EN     1'h0
`define SMBCC_RST_SW_AMT    2'h0
`define SMBCC_RST_AMP       2'h2
`define SMBCC_RST_SLEW      8'hff
`define SMBCC_RST_COUNT     5'h08
`define SMBCC_RST_STOP      2'h0

`define SMBCC_ADDR_SEL_LOW  7'h68
`define SMBCC_ADDR_SEL_HIGH 7'h6a

`define SMBCC_SYNC_INIT     13'h1fe3
`define SMBCC_LATCH_WAIT    3'h5
`define SMBCC_BITS_BYTE     4'h8

`endif

// ===== smbcc_pkg.sv
// Types shared by the clock config port.
package smbcc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_INDEX     = 4'b0011,
        ST_INDEX_ACK = 4'b0100,
        ST_COUNT     = 4'b0101,
        ST_COUNT_ACK = 4'b0110,
        ST_WDATA     = 4'b0111,
        ST_WDATA_ACK = 4'b1000,
        ST_RDATA     = 4'b1001,
        ST_MACK      = 4'b1010
    } smbcc_state_type;

endpackage

// ===== smbcc_sync.sv
// Three-stage pin synchroniser with agreement filter, one per bit.
module smbcc_sync #(
    parameter int          W    = 13,
    parameter logic [12:0] INIT = 13'h0
) (
    input  wire logic         CLK,
    input  wire logic         RST_B,
    input  wire logic [W-1:0] PIN,
    output logic      [W-1:0] LEVEL
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // A change is taken only once stages two and three agree.
            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    s1_q[i]  <= INIT[i];
                    s2_q[i]  <= INIT[i];
                    s3_q[i]  <= INIT[i];
                    LEVEL[i] <= INIT[i];
                end else begin
                    s1_q[i] <= PIN[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        LEVEL[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// ===== smbcc_port.sv
// SMBus slave port with the clock generator control registers.
`include "smbcc_consts.svh"
module smbcc_port (
    input  wire logic       CLK,
    input  wire logic       RST_B,
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    input  wire logic       SLAVE_ADDR_SELECT_PIN,
    input  wire logic [1:0] SPREAD_PIN_LEVEL,
    input  wire logic [7:0] OUTPUT_ENABLE_PIN_B,
    output logic      [7:0] OUTPUT_RUN,
    output logic      [1:0] STOP_STATE_FIELD,
    output logic      [1:0] SPREAD_AMOUNT,
    output logic      [1:0] AMPLITUDE,
    output logic      [7:0] SLEW_SELECT_BIT_N
);
    import smbcc_pkg::*;

    // ************************************************************
    // Pin synchronisation and power-up latches
    // ************************************************************
    logic [12:0] pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        addr_pin_s;
    logic [1:0]  spread_pin_s;
    logic [7:0]  oe_pin_b_s;

    smbcc_sync #(
        .W    (13),
        .INIT (`SMBCC_SYNC_INIT)
    ) u_sync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .PIN   ({OUTPUT_ENABLE_PIN_B, SPREAD_PIN_LEVEL,
                 SLAVE_ADDR_SELECT_PIN, SDA_IN, SCL}),
        .LEVEL (pins_s)
    );

    assign scl_s        = pins_s[0];
    assign sda_s        = pins_s[1];
    assign addr_pin_s   = pins_s[2];
    assign spread_pin_s = pins_s[4:3];
    assign oe_pin_b_s   = pins_s[12:5];

    logic [2:0] latch_cnt_q;
    logic       latched_q;
    logic       addr_sel_q;
    logic [1:0] spread_rb_q;

    // Wait past the filter so the reset image of the pins is never caught.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            latch_cnt_q <= 3'h0;
            latched_q   <= 1'b0;
            addr_sel_q  <= 1'b0;
            spread_rb_q <= 2'h0;
        end else if (!latched_q) begin
            if (latch_cnt_q == `SMBCC_LATCH_WAIT) begin
                latched_q   <= 1'b1;
                addr_sel_q  <= addr_pin_s;
                spread_rb_q <= spread_pin_s;
            end else begin
                latch_cnt_q <= latch_cnt_q + 3'h1;
            end
        end
    end

    // ************************************************************
    // Bus events
    // ************************************************************
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [6:0] my_addr;

    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign my_addr  = addr_sel_q ? `SMBCC_ADDR_SEL_HIGH
                                 : `SMBCC_ADDR_SEL_LOW;

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0] oe_q;
    logic       sw_en_q;
    logic [1:0] sw_amt_q;
    logic [1:0] amp_q;
    logic [7:0] slew_q;
    logic [4:0] count_q;
    logic [1:0] stop_q;
    logic [7:0] ptr_q;
    logic [7:0] rd_byte;
    logic [7:0] sh_q;
    logic [4:0] rem_q;
    logic       wr_en;
    smbcc_state_type st_q;
    logic [3:0] cnt_q;

    assign wr_en = (st_q == ST_WDATA) & scl_fall &
                   (cnt_q == `SMBCC_BITS_BYTE) & (rem_q != 5'h0);

    // Reserved bits and unmapped bytes read as zero.
    assign rd_byte =
        (ptr_q == `SMBCC_IDX_OE)     ? oe_q :
        (ptr_q == `SMBCC_IDX_SPREAD) ? {spread_rb_q, sw_en_q, sw_amt_q,
                                        1'b0, amp_q} :
        (ptr_q == `SMBCC_IDX_SLEW)   ? slew_q :
        (ptr_q == `SMBCC_IDX_COUNT)  ? {3'h0, count_q} :
        (ptr_q == `SMBCC_IDX_STOP)   ? {6'h0, stop_q} : 8'h00;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            oe_q     <= `SMBCC_RST_OE;
            sw_en_q  <= `SMBCC_RST_SW_EN;
            sw_amt_q <= `SMBCC_RST_SW_AMT;
            amp_q    <= `SMBCC_RST_AMP;
            slew_q   <= `SMBCC_RST_SLEW;
            count_q  <= `SMBCC_RST_COUNT;
            stop_q   <= `SMBCC_RST_STOP;
        end else if (wr_en) begin
            case (ptr_q)
                `SMBCC_IDX_OE:     oe_q    <= sh_q;
                `SMBCC_IDX_SPREAD: begin
                    sw_en_q  <= sh_q[5];
                    sw_amt_q <= sh_q[4:3];
                    amp_q    <= sh_q[1:0];
                end
                `SMBCC_IDX_SLEW:   slew_q  <= sh_q;
                `SMBCC_IDX_COUNT:  count_q <= sh_q[4:0];
                `SMBCC_IDX_STOP:   stop_q  <= sh_q[1:0];
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Protocol engine
    // ************************************************************
    logic [7:0] tx_q;
    logic       oe_drv_q;
    logic       mack_q;
    logic       rw_match;

    assign rw_match = (sh_q[7:1] == my_addr);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            st_q       <= ST_IDLE;
            cnt_q      <= 4'h0;
            sh_q       <= 8'h00;
            tx_q       <= 8'h00;
            ptr_q      <= 8'h00;
            rem_q      <= 5'h0;
            oe_drv_q   <= 1'b0;
            mack_q     <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            if (start_ev) begin
                st_q     <= ST_ADDR;
                cnt_q    <= 4'h0;
                oe_drv_q <= 1'b0;
            end else if (stop_ev) begin
                st_q     <= ST_IDLE;
                oe_drv_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], sda_s};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall &&
                                     cnt_q == `SMBCC_BITS_BYTE) begin
                            cnt_q    <= 4'h0;
                            oe_drv_q <= 1'b1;
                            case (st_q)
                                ST_ADDR: begin
                                    oe_drv_q <= rw_match;
                                    st_q <= rw_match ? ST_ADDR_ACK
                                                     : ST_IDLE;
                                end
                                ST_INDEX: begin
                                    ptr_q <= sh_q;
                                    st_q  <= ST_INDEX_ACK;
                                end
                                ST_COUNT: begin
                                    rem_q <= sh_q[4:0];
                                    st_q  <= ST_COUNT_ACK;
                                end
                                default: begin
                                    if (rem_q != 5'h0) begin
                                        ptr_q <= ptr_q + 8'h1;
                                        rem_q <= rem_q - 5'h1;
                                    end
                                    st_q <= ST_WDATA_ACK;
                                end
                            endcase
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (sh_q[0]) begin
                                tx_q     <= {3'h0, count_q};
                                // The count byte always opens with a zero.
                                oe_drv_q <= 1'b1;
                                st_q     <= ST_RDATA;
                            end else begin
                                oe_drv_q <= 1'b0;
                                st_q     <= ST_INDEX;
                            end
                        end
                    end
                    ST_INDEX_ACK, ST_COUNT_ACK, ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            oe_drv_q <= 1'b0;
                            st_q <= (st_q == ST_INDEX_ACK) ? ST_COUNT
                                                           : ST_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_q == `SMBCC_BITS_BYTE) begin
                                cnt_q    <= 4'h0;
                                oe_drv_q <= 1'b0;
                                st_q     <= ST_MACK;
                            end else begin
                                tx_q     <= {tx_q[6:0], 1'b0};
                                oe_drv_q <= ~tx_q[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_s;
                        end else if (scl_fall) begin
                            if (mack_q) begin
                                tx_q     <= rd_byte;
                                oe_drv_q <= ~rd_byte[7];
                                ptr_q    <= ptr_q + 8'h1;
                                st_q     <= ST_RDATA;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        oe_drv_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // The pin-latched spread is used unless software control is on.
    logic [1:0] spread_d;
    logic [7:0] run_d;

    assign spread_d = sw_en_q ? sw_amt_q : spread_rb_q;
    assign run_d    = oe_q & ~oe_pin_b_s;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            SDA_OUT           <= 1'b0;
            SDA_OE            <= 1'b0;
            OUTPUT_RUN        <= 8'h00;
            STOP_STATE_FIELD  <= `SMBCC_RST_STOP;
            SPREAD_AMOUNT     <= 2'h0;
            AMPLITUDE         <= `SMBCC_RST_AMP;
            SLEW_SELECT_BIT_N <= `SMBCC_RST_SLEW;
        end else begin
            SDA_OUT           <= 1'b0;
            SDA_OE            <= oe_drv_q;
            OUTPUT_RUN        <= run_d;
            STOP_STATE_FIELD  <= stop_q;
            SPREAD_AMOUNT     <= spread_d;
            AMPLITUDE         <= amp_q;
            SLEW_SELECT_BIT_N <= slew_q;
        end
    end
endmodule

// ===== smbcc_port_sva.sv
// Concurrent checks on the pins of the clock config port.
module smbcc_port_sva (
    input wire logic       CLK,
    input wire logic       RST_B,
    input wire logic       SCL,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE,
    input wire logic [7:0] OUTPUT_ENABLE_PIN_B,
    input wire logic [7:0] OUTPUT_RUN,
    input wire logic [1:0] STOP_STATE_FIELD,
    input wire logic [1:0] AMPLITUDE,
    input wire logic [7:0] SLEW_SELECT_BIT_N
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_pull;
        $rose(SDA_OE);
    endsequence
    sequence s_stand;
        SDA_OE [*8];
    endsequence
    property p_stand;
        s_pull |=> s_stand;
    endproperty
    a_stand: assert property (p_stand)
        else $error("SDA pull dropped too early");
    property p_release;
        s_pull |-> ##[1:300] !SDA_OE;
    endproperty
    a_release: assert property (p_release)
        else $error("SDA pull never released");
    // A pull that moves while SCL is high would fake a start or stop.
    property p_hold;
        SCL && $past(SCL) |-> $stable(SDA_OE);
    endproperty
    a_hold: assert property (p_hold)
        else $error("SDA pull changed while SCL high");
    property p_drain;
        SDA_OUT == 1'b0;
    endproperty
    a_drain: assert property (p_drain)
        else $error("SDA output value not low");
    property p_rst;
        $rose(RST_B) |-> AMPLITUDE == 2'h2 && SLEW_SELECT_BIT_N == 8'hff
            && STOP_STATE_FIELD == 2'h0 && !SDA_OE;
    endproperty
    a_rst: assert property (p_rst)
        else $error("Outputs wrong at reset release");
    property p_pin;
        $stable(OUTPUT_ENABLE_PIN_B) [*8]
            |-> (OUTPUT_RUN & OUTPUT_ENABLE_PIN_B) == 8'h00;
    endproperty
    a_pin: assert property (p_pin)
        else $error("Output runs with its enable pin high");
    property p_slew;
        $changed(SLEW_SELECT_BIT_N) |-> !SCL;
    endproperty
    a_slew: assert property (p_slew)
        else $error("Slew select changed outside a byte end");
    property p_amp;
        $changed(AMPLITUDE) |-> !SCL;
    endproperty
    a_amp: assert property (p_amp)
        else $error("Amplitude changed outside a byte end");
    property p_stop;
        $changed(STOP_STATE_FIELD) |-> !SCL;
    endproperty
    a_stop: assert property (p_stop)
        else $error("Stop state changed outside a byte end");
endmodule
bind smbcc_port smbcc_port_sva sva_u (
    .CLK(CLK),
    .RST_B(RST_B),
    .SCL(SCL),
    .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE),
    .OUTPUT_ENABLE_PIN_B(OUTPUT_ENABLE_PIN_B),
    .OUTPUT_RUN(OUTPUT_RUN),
    .STOP_STATE_FIELD(STOP_STATE_FIELD),
    .AMPLITUDE(AMPLITUDE),
    .SLEW_SELECT_BIT_N(SLEW_SELECT_BIT_N)
);

// ===== smbcc_host.sv
// SMBus host controller model driving the link for the bench.
module smbcc_host (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Bit and byte tasks
    // ****
    localparam int HALF = 8;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Half period is 160 ns: the device answers about 6 cycles late.
    task automatic bit_io(input logic b, output logic r);
        scl_drv = 1'b0;
        tick(2);
        sda_drv = b;
        tick(HALF - 2);
        scl_drv = 1'b1;
        r = sda_line;
        tick(HALF);
    endtask
    task automatic start();
        scl_drv = 1'b0;
        tick(2);
        sda_drv = 1'b1;
        tick(HALF - 2);
        scl_drv = 1'b1;
        tick(HALF);
        sda_drv = 1'b0;
        tick(HALF);
    endtask
    task automatic stop();
        scl_drv = 1'b0;
        tick(2);
        sda_drv = 1'b0;
        tick(HALF - 2);
        scl_drv = 1'b1;
        tick(HALF);
        sda_drv = 1'b1;
        tick(HALF);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, r);
    endtask
endmodule

// ===== smbcc_port_tb.sv
// Self-checking bench of the clock config port.
`include "smbcc_consts.svh"
module smbcc_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Stimulus and model
    // ****
    localparam logic [6:0] ADR = `SMBCC_ADDR_SEL_HIGH;
    localparam logic [1:0] SP_LAT = 2'b01;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        sel_pin = 1'b1;
    logic [1:0]  sp_pin = SP_LAT;
    logic [7:0]  oe_pin_b = 8'h00;
    logic        scl, h_sda, sda_oe, sda_out, sda_line;
    logic [7:0]  run, slew;
    logic [1:0]  stop_st, spread, amp;
    logic [7:0]  mdl [16];
    logic [31:0] rng = 32'd9;
    int          n_mismatch = 0;
    int          comparisons = 0;
    always #10 clk = ~clk;
    assign sda_line = h_sda & ~sda_oe;
    smbcc_port dut_u (
        .CLK(clk),
        .RST_B(rst_b),
        .SCL(scl),
        .SDA_IN(sda_line),
        .SDA_OUT(sda_out),
        .SDA_OE(sda_oe),
        .SLAVE_ADDR_SELECT_PIN(sel_pin),
        .SPREAD_PIN_LEVEL(sp_pin),
        .OUTPUT_ENABLE_PIN_B(oe_pin_b),
        .OUTPUT_RUN(run),
        .STOP_STATE_FIELD(stop_st),
        .SPREAD_AMOUNT(spread),
        .AMPLITUDE(amp),
        .SLEW_SELECT_BIT_N(slew)
    );
    smbcc_host host_u (
        .clk(clk),
        .sda_line(sda_line),
        .scl_drv(scl),
        .sda_drv(h_sda)
    );
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] wmask(input int i);
        case (i)
            0, 2: return 8'hff;
            1: return 8'h3b;
            7: return 8'h1f;
            11: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] rd(input int i);
        if (i == 1) return {SP_LAT, mdl[1][5:0]};
        return mdl[i];
    endfunction
    task automatic check(string what, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_outs();
        logic [1:0] sp;
        sp = mdl[1][5] ? mdl[1][4:3] : SP_LAT;
        check("run", mdl[0] & ~oe_pin_b, run);
        check("spread", {6'h0, sp}, {6'h0, spread});
        check("amp", {6'h0, mdl[1][1:0]}, {6'h0, amp});
        check("slew", mdl[2], slew);
        check("stop", {6'h0, mdl[11][1:0]}, {6'h0, stop_st});
    endtask
    // A negative v asks for random data bytes.
    task automatic blk_write(logic [6:0] a, int n, int x, int v, logic ok);
        logic       ack;
        logic [7:0] d;
        host_u.start();
        host_u.wbyte({a, 1'b0}, ack);
        check("addr ack", {7'h0, ok}, {7'h0, ack});
        if (!ok) begin
            host_u.stop();
            return;
        end
        host_u.wbyte(n[7:0], ack);
        check("index ack", 8'h01, {7'h0, ack});
        host_u.wbyte(x[7:0], ack);
        check("count ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < x; i++) begin
            rng = xs(rng);
            d = (v < 0) ? rng[7:0] : v[7:0];
            host_u.wbyte(d, ack);
            check("data ack", 8'h01, {7'h0, ack});
            mdl[n+i] = (mdl[n+i] & ~wmask(n + i)) | (d & wmask(n + i));
        end
        host_u.stop();
    endtask
    task automatic blk_read(int n);
        logic       ack;
        logic [7:0] d;
        int         x;
        host_u.start();
        host_u.wbyte({ADR, 1'b0}, ack);
        host_u.wbyte(n[7:0], ack);
        check("index ack", 8'h01, {7'h0, ack});
        host_u.start();
        host_u.wbyte({ADR, 1'b1}, ack);
        check("read addr ack", 8'h01, {7'h0, ack});
        x = int'(mdl[7][4:0]);
        host_u.rbyte(x == 0, d);
        check("count", mdl[7], d);
        for (int i = 0; i < x; i++) begin
            host_u.rbyte(i == x - 1, d);
            check("data", rd(n + i), d);
        end
        host_u.stop();
    endtask
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[0] = 8'hff;
        mdl[1] = 8'h02;
        mdl[2] = 8'hff;
        mdl[7] = 8'h08;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (12) @(negedge clk);
        // Pins move after the latch; address and readback must not follow.
        sel_pin = 1'b0;
        sp_pin = 2'b11;
        check_outs();
        blk_read(0);
        blk_write(`SMBCC_ADDR_SEL_LOW, 0, 1, -1, 1'b0);
        blk_write(ADR, 0, 4, -1, 1'b1);
        blk_write(ADR, 7, 1, 3, 1'b1);
        blk_write(ADR, 11, 1, -1, 1'b1);
        check_outs();
        rng = xs(rng);
        oe_pin_b = rng[7:0];
        repeat (12) @(negedge clk);
        check_outs();
        for (int c = 0; c < 5; c++) begin
            blk_write(ADR, 1, 1, (c < 4) ? (8'h20 | c * 9) : 8'h1b, 1'b1);
            check_outs();
        end
        blk_read(0);
        blk_read(1);
        test_done();
    end
endmodule
